// ===== hdl/sslkd_defs.vh
// Constants for the shared storage lock and timed wait block
// Assumes a 100 MHz hclk and an AHB-Lite register map at word-aligned byte offsets
`ifndef SSLKD_DEFS_VH
`define SSLKD_DEFS_VH
`define SSLKD_CLK_MHZ        100
`define SSLKD_TICK_US        256
`define SSLKD_TICK_CYC       (`SSLKD_TICK_US * `SSLKD_CLK_MHZ)
`define SSLKD_OFF_CTRL       8'h00
`define SSLKD_OFF_STATUS     8'h04
`define SSLKD_OFF_LOCKADDR   8'h08
`define SSLKD_OFF_COUNT      8'h0c
`define SSLKD_OFF_INTR       8'h10
`define SSLKD_OFF_RDATA      8'h14
`define SSLKD_CTRL_LOCK_BIT  0
`define SSLKD_CTRL_WAIT_BIT  1
`define SSLKD_ST_BUSY_BIT    0
`define SSLKD_ST_CC_BIT      1
`define SSLKD_ST_DONE_BIT    2
`define SSLKD_ST_EARLY_BIT   3
`define SSLKD_ST_NORMOP_BIT  4
`define SSLKD_INTR_IO_BIT    0
`define SSLKD_INTR_EXT_BIT   1
`define SSLKD_INTR_MCK_BIT   2
`define SSLKD_LOCK_BYTE      9'h1ff
`define SSLKD_RST_ADDR       24'h000000
`define SSLKD_RST_COUNT      8'h00
`define SSLKD_RST_IMASK      3'h7
`endif

// ===== hdl/sslkd_wait_timer.v
// Timed wait counter: N units of 256 us, cut short by an abort input
// Assumes start is a one-cycle pulse while idle
`timescale 1ns/1ps
`include "sslkd_defs.vh"
module sslkd_wait_timer #(
    parameter TICK_CYC = `SSLKD_TICK_CYC
) (
    input  wire       hclk,
    input  wire       hresetn,
    input  wire       start,
    input  wire [7:0] count_n,
    input  wire       abort,
    output reg        busy_q,
    output reg        done_q,
    output reg        early_q
);
    reg [7:0]  units_q;
    reg [31:0] tick_q;
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
            early_q <= 1'b0;
            units_q <= 8'h00;
            tick_q  <= 32'h0;
        end
        else
        begin
            done_q <= 1'b0;
            if (start && !busy_q)
            begin
                early_q <= 1'b0;
                tick_q  <= 32'h0;
                units_q <= count_n;
                if (count_n == 8'h00)
                    done_q <= 1'b1;
                else
                    busy_q <= 1'b1;
            end
            else if (busy_q)
            begin
                if (abort)
                begin
                    busy_q  <= 1'b0;
                    done_q  <= 1'b1;
                    early_q <= 1'b1;
                end
                // Timer service stretches wall time; nothing corrects for it
                else if (tick_q == TICK_CYC - 1)
                begin
                    tick_q  <= 32'h0;
                    units_q <= units_q - 8'h01;
                    if (units_q == 8'h01)
                    begin
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                    end
                end
                else
                    tick_q <= tick_q + 32'h1;
            end
        end
    end
endmodule

// ===== hdl/sslkd_top.v
// Lock test and timed wait engine of a processor element, AHB-Lite slave
// Assumes a storage element port that holds a granted requester for a locked pair
//
// Contract
// - Compute and I/O compute elements share this same logic for both operations.
// - Lock test reads the byte and sets the condition code to its leftmost bit.
// - Lock test writes the byte back as nine ones, parity included.
// - Lock test is only dependable while the normal-operation line is inactive.
// - The lock is logical; the storage element stays open to other requesters.
// - Any byte address may serve as the lock, with no block alignment.
// - Immediate AND, OR or XOR on storage hold the storage element for two cycles.
// - The timed wait takes an unsigned eight-bit count.
// - Each count unit waits about 256 microseconds.
// - A zero count finishes at once.
// - Timer service may stretch the wait and is not corrected for.
// - The wait ends at zero count or on an unmasked I/O, external or machine check.
`timescale 1ns/1ps
`include "sslkd_defs.vh"
module sslkd_top #(
    parameter TICK_CYC = `SSLKD_TICK_CYC,
    parameter IS_IO_ELEMENT = 0
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    output reg         se_req,
    output reg         se_we,
    output reg         se_lock,
    output reg  [23:0] se_addr,
    output reg  [8:0]  se_wdata,
    input  wire [8:0]  se_rdata,
    input  wire        se_ack,
    input  wire        normal_op,
    input  wire        rmw_imm,
    input  wire [23:0] rmw_addr,
    input  wire [8:0]  rmw_wdata,
    input  wire [2:0]  intr_pending,
    input  wire [2:0]  intr_mask,
    output reg         wait_busy,
    output reg         lock_busy
);
    localparam S_IDLE  = 3'd0;
    localparam S_FETCH = 3'd1;
    localparam S_STORE = 3'd2;
    localparam S_RMWF  = 3'd3;
    localparam S_RMWS  = 3'd4;

    reg [2:0]  st_q;
    reg        cc_q;
    reg        nop_seen_q;
    reg [23:0] laddr_q;
    reg [7:0]  cnt_q;
    reg [8:0]  rbyte_q;
    reg        wstart_q;
    reg        ph_q;
    reg        pw_q;
    reg [7:0]  pa_q;
    reg [2:0]  imask_q;
    reg        rmw_pend_q;
    reg [23:0] rmw_a_q;
    reg [8:0]  rmw_w_q;
    wire       t_busy;
    wire       t_done;
    wire       t_early;
    wire       abort;

    function [31:0] rd_mux;
        input [7:0] a;
        begin
            case (a)
                `SSLKD_OFF_STATUS:   rd_mux = {27'h0, nop_seen_q, t_early, t_done, cc_q, (st_q != S_IDLE)};
                `SSLKD_OFF_LOCKADDR: rd_mux = {8'h00, laddr_q};
                `SSLKD_OFF_COUNT:    rd_mux = {24'h0, cnt_q};
                `SSLKD_OFF_INTR:     rd_mux = {29'h0, imask_q};
                `SSLKD_OFF_RDATA:    rd_mux = {23'h0, rbyte_q};
                default:             rd_mux = 32'h0;
            endcase
        end
    endfunction

    // Only unmasked classes can cut a wait short; the element's own mask is folded in
    assign abort = |(intr_pending & intr_mask & imask_q);

    sslkd_wait_timer #(
        .TICK_CYC (TICK_CYC)
    ) u_timer (
        .hclk    (hclk),
        .hresetn (hresetn),
        .start   (wstart_q),
        .count_n (cnt_q),
        .abort   (abort),
        .busy_q  (t_busy),
        .done_q  (t_done),
        .early_q (t_early)
    );

    // Bus slave, zero wait states, always OKAY
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_q      <= 1'b0;
            pw_q      <= 1'b0;
            pa_q      <= 8'h00;
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            laddr_q   <= `SSLKD_RST_ADDR;
            cnt_q     <= `SSLKD_RST_COUNT;
            imask_q   <= `SSLKD_RST_IMASK;
            wstart_q  <= 1'b0;
        end
        else
        begin
            wstart_q <= 1'b0;
            ph_q <= hsel && hready && htrans[1];
            pw_q <= hwrite;
            pa_q <= haddr[7:0];
            if (hsel && hready && htrans[1] && !hwrite)
                hrdata <= rd_mux(haddr[7:0]);
            if (ph_q && pw_q)
            begin
                case (pa_q)
                    `SSLKD_OFF_CTRL:     wstart_q <= hwdata[`SSLKD_CTRL_WAIT_BIT] && !t_busy;
                    // Any byte address is accepted as a lock, no block alignment
                    `SSLKD_OFF_LOCKADDR: laddr_q  <= hwdata[23:0];
                    `SSLKD_OFF_COUNT:    cnt_q    <= hwdata[7:0];
                    `SSLKD_OFF_INTR:     imask_q  <= hwdata[2:0];
                    default:             ;
                endcase
            end
        end
    end

    // Storage sequencer, same for either element kind
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_q       <= S_IDLE;
            cc_q       <= 1'b0;
            nop_seen_q <= 1'b0;
            rbyte_q    <= 9'h000;
            se_req     <= 1'b0;
            se_we      <= 1'b0;
            se_lock    <= 1'b0;
            se_addr    <= 24'h0;
            se_wdata   <= 9'h000;
            rmw_pend_q <= 1'b0;
            rmw_a_q    <= 24'h0;
            rmw_w_q    <= 9'h000;
            wait_busy  <= 1'b0;
            lock_busy  <= 1'b0;
        end
        else
        begin
            wait_busy <= t_busy;
            lock_busy <= (st_q != S_IDLE);
            case (st_q)
                S_IDLE:
                begin
                    if (ph_q && pw_q && pa_q == `SSLKD_OFF_CTRL && hwdata[`SSLKD_CTRL_LOCK_BIT])
                    begin
                        st_q       <= S_FETCH;
                        nop_seen_q <= normal_op;
                        se_req     <= 1'b1;
                        se_we      <= 1'b0;
                        se_lock    <= 1'b1;
                        se_addr    <= laddr_q;
                    end
                    else if (rmw_pend_q)
                    begin
                        st_q    <= S_RMWF;
                        se_req  <= 1'b1;
                        se_we   <= 1'b0;
                        se_lock <= 1'b1;
                        se_addr <= rmw_a_q;
                    end
                end
                S_FETCH:
                begin
                    if (se_ack)
                    begin
                        rbyte_q  <= se_rdata;
                        cc_q     <= se_rdata[7];
                        se_we    <= 1'b1;
                        se_wdata <= `SSLKD_LOCK_BYTE;
                        st_q     <= S_STORE;
                    end
                    if (normal_op)
                        nop_seen_q <= 1'b1;
                end
                S_STORE:
                begin
                    if (se_ack)
                    begin
                        // Lock released here; other requesters are held off only during the fetch and store pair
                        se_req  <= 1'b0;
                        se_we   <= 1'b0;
                        se_lock <= 1'b0;
                        st_q    <= S_IDLE;
                    end
                end
                S_RMWF:
                begin
                    if (se_ack)
                    begin
                        se_we    <= 1'b1;
                        se_wdata <= rmw_w_q;
                        st_q     <= S_RMWS;
                    end
                end
                S_RMWS:
                begin
                    if (se_ack)
                    begin
                        se_req     <= 1'b0;
                        se_we      <= 1'b0;
                        se_lock    <= 1'b0;
                        rmw_pend_q <= 1'b0;
                        st_q       <= S_IDLE;
                    end
                end
                default:
                    st_q <= S_IDLE;
            endcase
            // Placed after the sequencer so a request in the pair's last cycle is not lost
            if (rmw_imm && (!rmw_pend_q || (st_q == S_RMWS && se_ack)))
            begin
                rmw_pend_q <= 1'b1;
                rmw_a_q    <= rmw_addr;
                rmw_w_q    <= rmw_wdata;
            end
        end
    end
endmodule

// ===== verification/sslkd_properties.sv
// Port checker for the lock test and timed wait engine
// Assumes binding to sslkd_top with the same TICK_CYC
`timescale 1ns/1ps
module sslkd_props #(
    parameter TICK_CYC = 4
) (
    input wire        hclk,
    input wire        hresetn,
    input wire        hreadyout,
    input wire        hresp,
    input wire        se_req,
    input wire        se_we,
    input wire        se_lock,
    input wire [23:0] se_addr,
    input wire [8:0]  se_wdata,
    input wire        se_ack,
    input wire        wait_busy,
    input wire        lock_busy
);
    reg [11:0] wcnt_q;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Length of the running wait; too long for a repetition
    always @(posedge hclk or negedge hresetn)
        if (!hresetn)
            wcnt_q <= 12'h000;
        else
            wcnt_q <= wait_busy ? wcnt_q + 12'h001 : 12'h000;
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus stalled or errored");
    a_fetch_locked: assert property (se_req && !se_we |-> se_lock) else $error("fetch unlocked");
    a_pair_held: assert property (se_req && !se_we && se_ack |=> se_req && se_we && se_lock
        && se_addr == $past(se_addr)) else $error("pair broken");
    a_req_steady: assert property (se_req && !se_ack |=> se_req && $stable(se_addr) && $stable(se_we))
        else $error("request dropped");
    a_nine_ones: assert property (se_req && se_we && lock_busy |-> se_wdata == 9'h1ff)
        else $error("write back not ones");
    a_lock_release: assert property (se_req && se_we && se_ack |=> !se_lock) else $error("lock kept");
    a_idle_free: assert property (!se_req |-> !se_lock) else $error("idle lock");
    a_wait_bound: assert property (wcnt_q <= 255 * TICK_CYC + 2) else $error("wait too long");
endmodule
bind sslkd_top sslkd_props #(.TICK_CYC(TICK_CYC)) prop_u (.*);

// ===== verification/sslkd_se_model.sv
// Storage element model serving one requester
// Assumes byte addresses below 16
`timescale 1ns/1ps
module sslkd_se_model (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        slow,
    input  wire        se_req,
    input  wire        se_we,
    input  wire [23:0] se_addr,
    input  wire [8:0]  se_wdata,
    output reg  [8:0]  se_rdata,
    output reg         se_ack
);
    reg [8:0] mem [0:15];
    reg [1:0] dly_q;
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            se_ack <= 1'b0;
            se_rdata <= 9'h0aa;
            dly_q <= 2'h0;
        end
        else if (se_req && !se_ack && dly_q == {slow, 1'b0})
        begin
            // Each request of a pair is acknowledged for one cycle once dly_q reaches 0, or 2 when slow
            se_ack <= 1'b1;
            dly_q <= 2'h0;
            if (se_we)
                mem[se_addr[3:0]] <= se_wdata;
            else
                se_rdata <= mem[se_addr[3:0]];
        end
        else
        begin
            // Released data is inverted every idle cycle, so the last byte is not held
            se_ack <= 1'b0;
            se_rdata <= ~se_rdata;
            dly_q <= (se_req && !se_ack) ? dly_q + 2'h1 : 2'h0;
        end
    end
endmodule

// ===== verification/tb_top.sv
// Bench for the lock test and timed wait engine
// Assumes a single AHB-Lite master and a short TICK_CYC
`timescale 1ns/1ps
module tb_top;
    reg         hclk = 1'b0;
    reg         hresetn = 1'b0;
    reg         hsel, hwrite, normal_op, rmw_imm, slow;
    reg  [31:0] haddr, hwdata;
    reg  [1:0]  htrans;
    reg  [23:0] rmw_addr;
    reg  [8:0]  rmw_wdata;
    reg  [2:0]  intr_pending, intr_mask;
    wire [31:0] hrdata;
    wire        hreadyout, hresp, se_req, se_we, se_lock, se_ack, wait_busy, lock_busy;
    wire [23:0] se_addr;
    wire [8:0]  se_wdata, se_rdata;
    int         err_count = 0;
    int         tests_run = 0;
    int         cyc = 0;
    int         i;
    sslkd_top #(.TICK_CYC(4)) dut_u (.hsize(3'b010), .hready(hreadyout), .*);
    sslkd_se_model se_u (.*);
    always #5 hclk = ~hclk;
    task automatic end_of_test;
        $display("Checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            end_of_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rdy;
        while (hreadyout !== 1'b1)
            @(posedge hclk);
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge hclk);
        rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        rdy();
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(a, 1'b1, d, x);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(a, 1'b0, 32'h0, x);
        chk($sformatf("reg %h", a), x, e);
    endtask
    task automatic lock(input logic [3:0] a, input logic [8:0] init, input logic cc);
        int n;
        logic [31:0] st;
        se_u.mem[a] = init;
        wr(8'h08, {28'h0, a});
        wr(8'h00, 32'h1);
        for (n = 0; n < 40 && lock_busy !== 1'b1; n++) @(posedge hclk);
        for (n = 0; n < 40 && lock_busy !== 1'b0; n++) @(posedge hclk);
        bus(8'h04, 1'b0, 32'h0, st);
        chk("cond code", st[1], cc);
        chk("normal seen", st[4], normal_op);
        rdc(8'h14, {23'h0, init});
        chk("stored byte", se_u.mem[a], 9'h1ff);
    endtask
    task automatic dly(input logic [7:0] cnt, input int lo, input int hi, input logic early);
        int n;
        logic [31:0] st;
        wr(8'h0c, {24'h0, cnt});
        wr(8'h00, 32'h2);
        for (n = 0; n < 4 && wait_busy !== 1'b1; n++) @(posedge hclk);
        for (n = 0; n < 2000 && wait_busy === 1'b1; n++) @(posedge hclk);
        chk("wait length", n >= lo && n <= hi, 1);
        bus(8'h04, 1'b0, 32'h0, st);
        chk("ended early", st[3], early);
    endtask
    initial
    begin
        {hsel, hwrite, normal_op, rmw_imm, slow} = 5'h00;
        {haddr, hwdata, htrans} = 66'h0;
        {rmw_addr, rmw_wdata, intr_pending} = 36'h0;
        intr_mask = 3'h7;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(8'h10, 32'h7);
        rdc(8'h0c, 32'h0);
        rdc(8'h20, 32'h0);
        lock(5, 9'h07f, 0);
        slow <= 1'b1;
        lock(5, 9'h1ff, 1);
        lock(13, 9'h080, 1);
        normal_op <= 1'b1;
        lock(2, 9'h17f, 0);
        {normal_op, slow} <= 2'b00;
        // Another processor's ordinary store frees the lock
        lock(5, 9'h000, 0);
        dly(0, 0, 1, 0);
        dly(3, 11, 14, 0);
        dly(255, 1019, 1022, 0);
        for (i = 0; i < 3; i++)
        begin
            wr(8'h10, 32'h7);
            fork
                dly(200, 1, 30, 1);
                begin
                    repeat (12) @(posedge hclk);
                    intr_pending <= 3'h1 << i;
                end
            join
            intr_pending <= 3'h0;
        end
        // Pending but disabled interrupts leave the wait alone
        intr_pending <= 3'h7;
        intr_mask <= 3'h0;
        dly(3, 11, 14, 0);
        {intr_pending, intr_mask} <= 6'h3f;
        wr(8'h10, 32'h0);
        dly(3, 11, 14, 0);
        {rmw_addr, rmw_wdata, rmw_imm} <= {24'h000009, 9'h1ff, 1'b1};
        @(posedge hclk);
        rmw_imm <= 1'b0;
        for (i = 0; i < 20 && se_u.mem[9] !== 9'h1ff; i++) @(posedge hclk);
        chk("pair store", se_u.mem[9], 9'h1ff);
        end_of_test();
    end
endmodule
